/* File: testbench/usb_device_state_regs_properties.sv */
// Port checker for usb_device_state_regs.
// Assumes one wait per bus request and registered state outputs.
`timescale 1ns/1ps
module usb_device_state_regs_properties (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Bus
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Link and state
   input wire logic i_usb_bus_reset,
   input wire logic o_usb_data_grant,
   input wire logic o_address_state,
   input wire logic o_configured,
   input wire logic [6:0] o_assigned_bus_address,
   input wire logic o_endpoint_function_enable,
   input wire logic [3:0] o_irq_enable
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   logic rd, wr0, wr1;
   logic [3:0] ie_bits;
   assign rd = i_avs_read && !o_avs_waitrequest;
   assign wr0 = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   assign wr1 = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[1];
   assign ie_bits = {i_avs_writedata[13], i_avs_writedata[11], i_avs_writedata[9],
      i_avs_writedata[8]};
   chk_state_read: assert property (rd && i_avs_address == 8'h04 |->
      o_avs_readdata == {30'h0, $past(o_configured), $past(o_address_state)})
      else $error("state readback");
   // Bus reset is held long enough that its level is seen three edges back
   chk_addr_sticky: assert property ($fell(o_address_state) |->
      $past(i_rst) || $past(i_usb_bus_reset, 3)) else $error("address flag dropped");
   chk_addr_set: assert property (wr0 && i_avs_address == 8'h04 && i_avs_writedata[0]
      |=> o_address_state) else $error("address flag not set");
   chk_cfg_write: assert property (wr0 && i_avs_address == 8'h04 |=>
      o_configured == $past(i_avs_writedata[1])) else $error("configured flag");
   chk_addr_write: assert property (wr0 && i_avs_address == 8'h08 |=>
      o_assigned_bus_address == $past(i_avs_writedata[6:0])) else $error("address value");
   chk_fen_write: assert property (wr1 && i_avs_address == 8'h08 |=>
      o_endpoint_function_enable == $past(i_avs_writedata[8])) else $error("function enable");
   chk_grant_gate: assert property (o_usb_data_grant |->
      o_endpoint_function_enable) else $error("grant");
   chk_irq_set: assert property (wr1 && i_avs_address == 8'h10 |=>
      o_irq_enable == ($past(o_irq_enable) | $past(ie_bits))) else $error("irq enable set");
   chk_wo_read: assert property (rd && i_avs_address == 8'h10 |->
      o_avs_readdata == 32'h0000_0000) else $error("write-only reads nonzero");
   chk_reset_values: assert property ($past(i_rst) |->
      o_assigned_bus_address == 7'h00 && o_endpoint_function_enable && !o_address_state
      && !o_configured) else $error("reset values");
   chk_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("more than one wait");
endmodule
bind usb_device_state_regs usb_device_state_regs_properties i_props (.*);

/* File: testbench/usb_device_state_regs_tb.sv */
// Self-checking bench for usb_device_state_regs against a reference model.
// Assumes the host model drives the link pins.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module usb_device_state_regs_tb;
   localparam logic [7:0] DS = usb_state_pkg::OFF_DEVICE_STATE;
   localparam logic [7:0] DA = usb_state_pkg::OFF_DEVICE_ADDRESS;
   localparam logic [7:0] IES = usb_state_pkg::OFF_IRQ_ENABLE_SET;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0000_0000;
   logic [3:0] i_avs_byteenable = 4'hf;
   logic [31:0] o_avs_readdata, q, d, m_state, m_addr, m_ie;
   logic o_avs_waitrequest, i_usb_bus_reset, i_usb_data_request, o_usb_data_grant;
   logic o_address_state, o_configured, o_endpoint_function_enable, o_irq;
   logic [6:0] o_assigned_bus_address;
   logic [3:0] o_irq_enable;
   int bad_count = 0;
   int n_compared = 0;

   always #25 i_sys_clk = ~i_sys_clk;
   usb_device_state_regs i_dut (.*);
   usb_host_model i_host (.i_sys_clk(i_sys_clk), .o_bus_reset(i_usb_bus_reset),
      .o_data_request(i_usb_data_request));

   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Idle edge first, so a release and the next request never share a step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_sys_clk);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= wd;
      // A wait ends when waitrequest is low; only the watchdog ends one that never does
      do begin
         @(posedge i_sys_clk);
      end while (o_avs_waitrequest !== 1'b0);
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK(q, e)
   endtask

   initial begin
      d = $urandom(54);
      repeat (12) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rd_chk(DS, 32'h0000_0000);
      rd_chk(DA, 32'h0000_0100);
      rd_chk(8'h0c, 32'h0000_0000);
      rd_chk(usb_state_pkg::OFF_IRQ_MASK, 32'h0000_0000);
      // Event while masked, then unmasked, then cleared by a status read
      i_host.bus_reset();
      repeat (8) @(posedge i_sys_clk);
      `CHK(o_irq, 1'b0)
      xfer(1'b1, usb_state_pkg::OFF_EVENT_MASK, 32'h0000_0001);
      repeat (3) @(posedge i_sys_clk);
      `CHK(o_irq, 1'b1)
      rd_chk(usb_state_pkg::OFF_EVENT_STATUS, 32'h0000_0001);
      repeat (3) @(posedge i_sys_clk);
      `CHK(o_irq, 1'b0)
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         xfer(1'b1, DA, d);
         m_addr = d & 32'h0000_017f;
         rd_chk(DA, m_addr);
         `CHK(o_assigned_bus_address, m_addr[6:0])
      end
      i_host.request(1'b1);
      xfer(1'b1, DA, 32'h0000_0000);
      repeat (6) @(posedge i_sys_clk);
      `CHK(o_usb_data_grant, 1'b0)
      xfer(1'b1, DA, 32'h0000_0125);
      repeat (6) @(posedge i_sys_clk);
      `CHK(o_usb_data_grant, 1'b1)
      i_host.request(1'b0);
      m_addr = 32'h0000_0125;
      xfer(1'b1, DS, 32'h0000_0001);
      rd_chk(DS, 32'h0000_0001);
      xfer(1'b1, DS, 32'h0000_0000);
      rd_chk(DS, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         xfer(1'b1, DS, d);
         m_state = {30'h0, d[1], 1'b1};
         rd_chk(DS, m_state);
      end
      i_host.bus_reset();
      repeat (8) @(posedge i_sys_clk);
      rd_chk(DS, 32'h0000_0000);
      rd_chk(DA, m_addr & 32'h0000_0100);
      m_ie = 32'h0000_0000;
      for (int i = 0; i < 3; i++) begin
         d = (i == 2) ? 32'h0000_0000 : $urandom;
         xfer(1'b1, IES, d);
         m_ie = m_ie | (d & usb_state_pkg::IRQ_BITS_MASK);
         rd_chk(usb_state_pkg::OFF_IRQ_MASK, m_ie);
         rd_chk(IES, 32'h0000_0000);
         `CHK(o_irq_enable, {m_ie[13], m_ie[11], m_ie[9], m_ie[8]})
      end
      // Mid-run reset from a non-default state
      xfer(1'b1, DA, 32'h0000_007f);
      xfer(1'b1, DS, 32'h0000_0003);
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      rd_chk(DS, 32'h0000_0000);
      rd_chk(DA, 32'h0000_0100);
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge i_sys_clk);
      bad_count++;
      report_and_stop();
   end
endmodule

/* File: testbench/usb_host_model.sv */
// Behavioural USB host: bus reset pulses and endpoint data requests.
// Assumes it is called from the bench process, paced by i_sys_clk.
`timescale 1ns/1ps
module usb_host_model (
   // Clock
   input wire logic i_sys_clk,
   // Link pins
   output logic o_bus_reset,
   output logic o_data_request
);
   initial begin
      o_bus_reset = 1'b0;
      o_data_request = 1'b0;
   end
   // Six cycles so the two-flop sync cannot miss it
   task automatic bus_reset();
      @(posedge i_sys_clk);
      o_bus_reset <= 1'b1;
      repeat (6) @(posedge i_sys_clk);
      o_bus_reset <= 1'b0;
   endtask
   task automatic request(input logic v);
      @(posedge i_sys_clk);
      o_data_request <= v;
   endtask
endmodule

/* File: verilog/sync_bit.sv */
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to i_sys_clk.
`timescale 1ns/1ps
module sync_bit #(
   parameter logic RESET_VALUE = 1'b0
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Level
   input wire logic i_async,
   output logic o_sync
);

   logic stage1;
   logic next_stage1;
   logic next_sync;

   // No reset mux ahead of the first stage: only a wire meets the pin
   always_comb begin
      next_stage1 = i_async;
      next_sync = stage1;
      if (i_rst) begin
         next_sync = RESET_VALUE;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
   end

endmodule

/* File: verilog/usb_device_state_regs.sv */
// USB device state registers: address/configured flags, function
// address, endpoint enable and interrupt enables, over Avalon-MM.
// Assumes bus reset and data-request pins come from the USB link side,
// asynchronous to i_sys_clk.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module usb_device_state_regs (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // USB link side
   input wire logic i_usb_bus_reset,
   input wire logic i_usb_data_request,
   output logic o_usb_data_grant,
   // Device state out
   output logic o_address_state,
   output logic o_configured,
   output logic [6:0] o_assigned_bus_address,
   output logic o_endpoint_function_enable,
   output logic [3:0] o_irq_enable,
   // Interrupt
   output logic o_irq
);

   localparam int EW = usb_state_pkg::EVT_COUNT;

   // Synchronised link pins
   logic bus_reset_s;
   logic data_request_s;
   logic bus_reset_d;

   sync_bit #(.RESET_VALUE(1'b0)) u_sync_reset (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async(i_usb_bus_reset),
      .o_sync(bus_reset_s)
   );

   sync_bit #(.RESET_VALUE(1'b0)) u_sync_req (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async(i_usb_data_request),
      .o_sync(data_request_s)
   );

   // Bus handshake
   // One wait cycle: request held with waitrequest high, answered next edge.
   logic bus_ack;
   logic next_bus_ack;
   logic waitrequest;
   logic next_waitrequest;
   logic [31:0] next_readdata;
   logic bus_req;
   logic wr_hit;
   logic rd_take;
   logic [31:0] wmask;

   assign bus_req = (i_avs_read | i_avs_write) & ~bus_ack;
   assign wr_hit = i_avs_write & bus_ack;
   // Read data captured as the request is taken, so it stands in the answer cycle
   assign rd_take = i_avs_read & bus_req;
   assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                   {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

   // Device state registers
   logic address_state;
   logic configured;
   logic [6:0] bus_address;
   logic function_enable;
   logic [3:0] irq_enable;
   logic [EW-1:0] evt_status;
   logic [EW-1:0] evt_mask;
   logic data_grant;
   logic irq;

   logic next_address_state;
   logic next_configured;
   logic [6:0] next_bus_address;
   logic next_function_enable;
   logic [3:0] next_irq_enable;
   logic [EW-1:0] next_evt_status;
   logic [EW-1:0] next_evt_mask;
   logic next_data_grant;
   logic next_irq;
   logic next_bus_reset_d;

   logic [31:0] wdata;
   logic [3:0] irq_wr_bits;
   logic [EW-1:0] evt_set;
   logic [31:0] rd_value;

   assign wdata = i_avs_writedata & wmask;

   // Packs the four enables into their register positions
   function automatic logic [31:0] pack_irq(input logic [3:0] en);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[usb_state_pkg::BIT_SUSPEND_IRQ] = en[0];
      v[usb_state_pkg::BIT_RESUME_IRQ] = en[1];
      v[usb_state_pkg::BIT_FRAME_START_IRQ] = en[2];
      v[usb_state_pkg::BIT_WAKEUP_IRQ] = en[3];
      return v;
   endfunction

   always_comb begin
      irq_wr_bits = {wdata[usb_state_pkg::BIT_WAKEUP_IRQ],
                     wdata[usb_state_pkg::BIT_FRAME_START_IRQ],
                     wdata[usb_state_pkg::BIT_RESUME_IRQ],
                     wdata[usb_state_pkg::BIT_SUSPEND_IRQ]};
   end

   // Register read mux
   always_comb begin
      rd_value = 32'h0000_0000;
      unique case (i_avs_address)
         usb_state_pkg::OFF_DEVICE_STATE: begin
            rd_value[usb_state_pkg::BIT_ADDRESS_STATE] = address_state;
            rd_value[usb_state_pkg::BIT_CONFIGURED] = configured;
         end
         usb_state_pkg::OFF_DEVICE_ADDRESS: begin
            rd_value[6:0] = bus_address;
            rd_value[usb_state_pkg::BIT_FUNCTION_ENABLE] = function_enable;
         end
         usb_state_pkg::OFF_IRQ_MASK: begin
            rd_value = pack_irq(irq_enable);
         end
         usb_state_pkg::OFF_EVENT_MASK: begin
            rd_value[EW-1:0] = evt_mask;
         end
         usb_state_pkg::OFF_EVENT_STATUS: begin
            rd_value[EW-1:0] = evt_status;
         end
         default: begin
            rd_value = 32'h0000_0000;
         end
      endcase
   end

   // Events
   always_comb begin
      evt_set = '0;
      evt_set[usb_state_pkg::EVT_BUS_RESET] = bus_reset_s & ~bus_reset_d;
      evt_set[usb_state_pkg::EVT_ADDRESSED] = wr_hit
         & (i_avs_address == usb_state_pkg::OFF_DEVICE_STATE)
         & wdata[usb_state_pkg::BIT_ADDRESS_STATE] & ~address_state;
      evt_set[usb_state_pkg::EVT_CONFIG_CHANGE] = wr_hit
         & (i_avs_address == usb_state_pkg::OFF_DEVICE_STATE)
         & (wdata[usb_state_pkg::BIT_CONFIGURED] != configured)
         & i_avs_byteenable[0];
   end

   always_comb begin
      next_bus_ack = bus_req;
      next_readdata = rd_take ? rd_value : 32'h0000_0000;
      next_address_state = address_state;
      next_configured = configured;
      next_bus_address = bus_address;
      next_function_enable = function_enable;
      next_irq_enable = irq_enable;
      next_evt_mask = evt_mask;
      next_evt_status = evt_status;
      next_bus_reset_d = bus_reset_s;
      if (wr_hit) begin
         unique case (i_avs_address)
            usb_state_pkg::OFF_DEVICE_STATE: begin
               if (i_avs_byteenable[0]) begin
                  // Zero leaves address state alone
                  if (wdata[usb_state_pkg::BIT_ADDRESS_STATE]) begin
                     next_address_state = 1'b1;
                  end
                  next_configured = wdata[usb_state_pkg::BIT_CONFIGURED];
               end
            end
            usb_state_pkg::OFF_DEVICE_ADDRESS: begin
               if (i_avs_byteenable[0]) begin
                  next_bus_address = wdata[6:0];
               end
               if (i_avs_byteenable[1]) begin
                  next_function_enable = wdata[usb_state_pkg::BIT_FUNCTION_ENABLE];
               end
            end
            usb_state_pkg::OFF_IRQ_ENABLE_SET: begin
               next_irq_enable = irq_enable | irq_wr_bits;
            end
            usb_state_pkg::OFF_IRQ_ENABLE_CLR: begin
               next_irq_enable = irq_enable & ~irq_wr_bits;
            end
            usb_state_pkg::OFF_EVENT_MASK: begin
               next_evt_mask = wdata[EW-1:0];
            end
            default: begin
               next_evt_mask = evt_mask;
            end
         endcase
      end
      // Read clears status; a same-cycle event still lands
      // Cleared with the capture, so an event after it is never lost
      if (rd_take && i_avs_address == usb_state_pkg::OFF_EVENT_STATUS) begin
         next_evt_status = '0;
      end
      next_evt_status = next_evt_status | evt_set;
      // A host bus reset returns the device to the default state
      if (evt_set[usb_state_pkg::EVT_BUS_RESET]) begin
         next_address_state = 1'b0;
         next_configured = 1'b0;
         next_bus_address = usb_state_pkg::RST_ADDRESS;
      end
      // Grant drops on the same edge as the enable
      next_data_grant = data_request_s & next_function_enable;
      next_irq = |(next_evt_status & next_evt_mask);
      if (i_rst) begin
         next_bus_ack = 1'b0;
         next_readdata = 32'h0000_0000;
         next_address_state = 1'b0;
         next_configured = 1'b0;
         next_bus_address = usb_state_pkg::RST_ADDRESS;
         next_function_enable = usb_state_pkg::RST_FUNCTION_ENABLE;
         next_irq_enable = usb_state_pkg::RST_IRQ_ENABLE;
         next_evt_mask = '0;
         next_evt_status = '0;
         next_data_grant = 1'b0;
         next_irq = 1'b0;
         next_bus_reset_d = 1'b0;
      end
      next_waitrequest = ~next_bus_ack;
   end

   always_ff @(posedge i_sys_clk) begin
      bus_ack <= next_bus_ack;
      waitrequest <= next_waitrequest;
      o_avs_readdata <= next_readdata;
      address_state <= next_address_state;
      configured <= next_configured;
      bus_address <= next_bus_address;
      function_enable <= next_function_enable;
      irq_enable <= next_irq_enable;
      evt_mask <= next_evt_mask;
      evt_status <= next_evt_status;
      data_grant <= next_data_grant;
      irq <= next_irq;
      bus_reset_d <= next_bus_reset_d;
   end

   // Waitrequest low only in the answer cycle
   always_comb begin
      o_avs_waitrequest = waitrequest;
   end

   always_comb begin
      o_address_state = address_state;
      o_configured = configured;
      o_assigned_bus_address = bus_address;
      o_endpoint_function_enable = function_enable;
      o_irq_enable = irq_enable;
      o_usb_data_grant = data_grant;
      o_irq = irq;
   end

endmodule

/* File: verilog/usb_state_pkg.sv */
// Package for the USB device state register block.
// Holds register offsets, field positions, reset values and irq layout.
package usb_state_pkg;

   // Register byte offsets (word aligned)
   localparam logic [7:0] OFF_DEVICE_STATE = 8'h04;
   localparam logic [7:0] OFF_DEVICE_ADDRESS = 8'h08;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE_CLR = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
   localparam logic [7:0] OFF_EVENT_MASK = 8'h40;
   localparam logic [7:0] OFF_EVENT_STATUS = 8'h44;

   // Device state fields
   localparam int BIT_ADDRESS_STATE = 0;
   localparam int BIT_CONFIGURED = 1;

   // Device address fields
   localparam int ADDR_LSB = 0;
   localparam int ADDR_WIDTH = 7;
   localparam int BIT_FUNCTION_ENABLE = 8;

   // Interrupt enable fields
   localparam int BIT_SUSPEND_IRQ = 8;
   localparam int BIT_RESUME_IRQ = 9;
   localparam int BIT_FRAME_START_IRQ = 11;
   localparam int BIT_WAKEUP_IRQ = 13;
   localparam logic [31:0] IRQ_BITS_MASK = 32'h0000_2b00;

   // Reset values
   localparam logic [6:0] RST_ADDRESS = 7'h00;
   // Endpoints come out of reset enabled
   localparam logic RST_FUNCTION_ENABLE = 1'b1;
   localparam logic [3:0] RST_IRQ_ENABLE = 4'h0;

   // Block event status bits
   localparam int EVT_BUS_RESET = 0;
   localparam int EVT_ADDRESSED = 1;
   localparam int EVT_CONFIG_CHANGE = 2;
   localparam int EVT_COUNT = 3;

endpackage
